// [include/sysref_window_cfg.svh]
`ifndef SYSREF_WINDOW_CFG_SVH
`define SYSREF_WINDOW_CFG_SVH

// ----------------------------------------------------------------------------
// tap geometry
// ----------------------------------------------------------------------------
`define SRW_TAP_COUNT        24
`define SRW_SEL_TAPS         16
`define SRW_SEL_WIDTH        4
`define SRW_FIRST_TAP        0
`define SRW_LAST_TAP         23

// ----------------------------------------------------------------------------
// register map, byte offsets of the status bytes
// ----------------------------------------------------------------------------
`define SRW_ADDR_WIDTH       8
`define SRW_OFS_STATUS_LOW   8'h2C
`define SRW_OFS_STATUS_MID   8'h2D
`define SRW_OFS_STATUS_HIGH  8'h2E
`define SRW_UNMAPPED_DATA    8'h00

// ----------------------------------------------------------------------------
// reset values and counter defaults
// ----------------------------------------------------------------------------
`define SRW_STATUS_RESET     24'h800001
`define SRW_FRAME_CNT_WIDTH  16
`define SRW_FRAME_PERIOD_DEF 16'h001F

`endif

// [include/sysref_window_pkg.sv]
package sysref_window_pkg;

  // register read request from the control port
  typedef struct packed {
    logic       rd;
    logic [7:0] addr;
  } reg_req_type;

  // register read answer
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } reg_rsp_type;

  // capture state: waiting for an edge or tracking one
  typedef enum logic [1:0] {
    CAP_IDLE  = 2'b00,
    CAP_HIGH  = 2'b01
  } cap_state_type;

endpackage

// [design/sysref_window_detect.sv]
`timescale 1ns/1ps
`default_nettype none

`include "sysref_window_cfg.svh"

module sysref_window_detect
  import sysref_window_pkg::*;
#(
  parameter int TAPS = `SRW_TAP_COUNT
)
(
  input  wire logic            mclk_in,
  input  wire logic            arst_n_in,
  input  wire logic            clear_in,
  input  wire logic [TAPS-1:0] tap_sample_in,
  output logic      [TAPS-1:0] window_status_out
);

  logic [TAPS-1:0] window_status;
  logic [TAPS-1:0] disagree;
  logic [TAPS-1:0] next_window_status;

  // ---------------------------------------------------------------------------
  // neighbour comparison
  // ---------------------------------------------------------------------------
  // a tap whose sample differs from a neighbour sits on the sysref edge
  genvar g;
  generate
    for (g = 0; g < TAPS; g++)
    begin : g_cmp
      if (g == 0 || g == TAPS-1)
      begin : g_end
        assign disagree[g] = 1'b1;
      end
      else
      begin : g_mid
        assign disagree[g] = (tap_sample_in[g] ^ tap_sample_in[g-1]) |
                             (tap_sample_in[g] ^ tap_sample_in[g+1]);
      end
    end
  endgenerate

  // sticky until cleared; a hit in the clear cycle still lands
  assign next_window_status = clear_in ? disagree
                                       : (window_status | disagree);

  // status accumulates over every observed sysref edge
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      window_status <= TAPS'(`SRW_STATUS_RESET);
    else
      window_status <= next_window_status;
  end

  assign window_status_out = window_status;

endmodule

`default_nettype wire

// [design/sysref_window_capture.sv]
`timescale 1ns/1ps
`default_nettype none

`include "sysref_window_cfg.svh"

module sysref_window_capture
  import sysref_window_pkg::*;
#(
  parameter int TAPS      = `SRW_TAP_COUNT,
  parameter int SEL_W     = `SRW_SEL_WIDTH,
  parameter int CNT_W     = `SRW_FRAME_CNT_WIDTH
)
(
  input  wire logic             mclk_in,
  input  wire logic             arst_n_in,
  input  wire logic [TAPS-1:0]  sysref_tap_in,
  input  wire logic [SEL_W-1:0] capture_tap_select_in,
  input  wire logic             fine_step_enable_in,
  input  wire logic             window_clear_in,
  input  wire logic [CNT_W-1:0] frame_period_in,
  input  wire reg_req_type      reg_req_in,
  output reg_rsp_type           reg_rsp_out,
  output logic                  fine_step_enable_out,
  output logic                  sysref_captured_out,
  output logic [CNT_W-1:0]      frame_count_out,
  output logic                  frame_boundary_out
);

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  logic [TAPS-1:0]  tap_meta;
  logic [TAPS-1:0]  tap_sync;
  logic [TAPS-1:0]  window_status;
  logic             fine_step;
  logic             fine_step_changed;
  logic             detect_clear;
  logic             selected_tap;
  logic             captured;
  logic             next_captured;
  cap_state_type    cap_state;
  cap_state_type    next_cap_state;
  logic [CNT_W-1:0] frame_count;
  logic [CNT_W-1:0] next_frame_count;
  logic             frame_wrap;
  logic             frame_boundary;
  logic             hit_low;
  logic             hit_mid;
  logic             hit_high;
  logic [7:0]       next_rd_data;
  reg_rsp_type      rsp;

  // ---------------------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------------------
  // pick one status byte; byte 0 holds the smallest delays
  function automatic logic [7:0] status_byte(input logic [TAPS-1:0] st,
                                             input int              idx);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      if (idx*8 + i < TAPS)
        b[i] = st[idx*8 + i];
    end
    return b;
  endfunction

  // ---------------------------------------------------------------------------
  // tap synchronisers
  // ---------------------------------------------------------------------------
  // each delayed tap is asynchronous to the device clock, so each sample
  // goes through two stages before anyone looks at it; with windowing
  // the first stage may go metastable without harm
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      tap_meta <= '0;
      tap_sync <= '0;
    end
    else
    begin
      tap_meta <= sysref_tap_in;
      tap_sync <= tap_meta;
    end
  end

  // ---------------------------------------------------------------------------
  // tap spacing control
  // ---------------------------------------------------------------------------
  // registered so the delay line sees a clean level; a change of spacing
  // invalidates the old window, so it restarts the measurement
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      fine_step <= 1'b1;
    else
      fine_step <= fine_step_enable_in;
  end

  assign fine_step_changed    = fine_step ^ fine_step_enable_in;
  assign detect_clear         = window_clear_in | fine_step_changed;
  assign fine_step_enable_out = fine_step;

  // ---------------------------------------------------------------------------
  // window position detector
  // ---------------------------------------------------------------------------
  sysref_window_detect #(
    .TAPS              (TAPS)
  ) u_detect (
    .mclk_in           (mclk_in),
    .arst_n_in         (arst_n_in),
    .clear_in          (detect_clear),
    .tap_sample_in     (tap_sync),
    .window_status_out (window_status)
  );

  // ---------------------------------------------------------------------------
  // capture at the selected tap
  // ---------------------------------------------------------------------------
  // select is 4 bits wide, so only the first sixteen taps can be reached
  assign selected_tap = tap_sync[capture_tap_select_in];

  // one capture pulse per rising sysref edge, pulse or periodic alike
  always_comb
  begin
    next_cap_state = cap_state;
    next_captured  = 1'b0;
    case (cap_state)
      CAP_IDLE:
      begin
        if (selected_tap)
        begin
          next_cap_state = CAP_HIGH;
          next_captured  = 1'b1;
        end
      end
      CAP_HIGH:
      begin
        if (!selected_tap)
          next_cap_state = CAP_IDLE;
      end
      default:
      begin
        next_cap_state = CAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cap_state <= CAP_IDLE;
      captured  <= 1'b0;
    end
    else
    begin
      cap_state <= next_cap_state;
      captured  <= next_captured;
    end
  end

  assign sysref_captured_out = captured;

  // ---------------------------------------------------------------------------
  // multiframe / extended multiblock counter
  // ---------------------------------------------------------------------------
  // period is count-1; a periodic sysref at an integer fraction of the
  // frame rate lands on a wrap, so the reset leaves the phase unchanged
  assign frame_wrap       = (frame_count == frame_period_in);
  assign next_frame_count = (captured || frame_wrap) ? '0
                          : frame_count + CNT_W'(1);

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      frame_count    <= '0;
      frame_boundary <= 1'b0;
    end
    else
    begin
      frame_count    <= next_frame_count;
      frame_boundary <= captured | frame_wrap;
    end
  end

  assign frame_count_out    = frame_count;
  assign frame_boundary_out = frame_boundary;

  // ---------------------------------------------------------------------------
  // status register read port
  // ---------------------------------------------------------------------------
  // status is read-only; unmapped reads answer zero
  assign hit_low  = (reg_req_in.addr == `SRW_OFS_STATUS_LOW);
  assign hit_mid  = (reg_req_in.addr == `SRW_OFS_STATUS_MID);
  assign hit_high = (reg_req_in.addr == `SRW_OFS_STATUS_HIGH);

  assign next_rd_data = hit_low  ? status_byte(window_status, 0)
                      : hit_mid  ? status_byte(window_status, 1)
                      : hit_high ? status_byte(window_status, 2)
                      : `SRW_UNMAPPED_DATA;

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rsp <= '0;
    else
    begin
      rsp.valid <= reg_req_in.rd;
      rsp.data  <= reg_req_in.rd ? next_rd_data : rsp.data;
    end
  end

  assign reg_rsp_out = rsp;

endmodule

`default_nettype wire

// [tb/sysref_window_capture_props.sv]
`timescale 1ns/1ps
`default_nettype none
module sysref_window_capture_props
  import sysref_window_pkg::*;
#(
  parameter int TAPS  = 24,
  parameter int SEL_W = 4,
  parameter int CNT_W = 16
)
(
  input wire logic             mclk_in,
  input wire logic             arst_n_in,
  input wire logic [TAPS-1:0]  sysref_tap_in,
  input wire logic [SEL_W-1:0] capture_tap_select_in,
  input wire logic             fine_step_enable_in,
  input wire logic             window_clear_in,
  input wire logic [CNT_W-1:0] frame_period_in,
  input wire reg_req_type      reg_req_in,
  input wire reg_rsp_type      reg_rsp_out,
  input wire logic             fine_step_enable_out,
  input wire logic             sysref_captured_out,
  input wire logic [CNT_W-1:0] frame_count_out,
  input wire logic             frame_boundary_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  // counter reload seen on the cycle after its cause
  sequence s_reload;
    frame_count_out == '0 && frame_boundary_out;
  endsequence
  property p_rsp_next;
    reg_req_in.rd |=> reg_rsp_out.valid;
  endproperty
  a_rsp_next: assert property (p_rsp_next) else $error("answer missing");
  property p_rsp_quiet;
    !reg_req_in.rd |=> !reg_rsp_out.valid;
  endproperty
  a_rsp_quiet: assert property (p_rsp_quiet) else $error("stray answer");
  property p_end_low;
    reg_req_in.rd && reg_req_in.addr == 8'h2C |=> reg_rsp_out.data[0];
  endproperty
  a_end_low: assert property (p_end_low) else $error("tap 0 clear");
  property p_end_high;
    reg_req_in.rd && reg_req_in.addr == 8'h2E |=> reg_rsp_out.data[7];
  endproperty
  a_end_high: assert property (p_end_high) else $error("tap 23 clear");
  property p_cap_pulse;
    sysref_captured_out |=> !sysref_captured_out;
  endproperty
  a_cap_pulse: assert property (p_cap_pulse) else $error("long pulse");
  property p_cap_reload;
    sysref_captured_out |=> s_reload;
  endproperty
  a_cap_reload: assert property (p_cap_reload) else $error("no reload");
  property p_wrap;
    frame_count_out == frame_period_in && !sysref_captured_out |=> s_reload;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");
  property p_count;
    frame_count_out != frame_period_in && !sysref_captured_out |=>
      frame_count_out == $past(frame_count_out) + 1'b1 && !frame_boundary_out;
  endproperty
  a_count: assert property (p_count) else $error("bad count");
  property p_fine;
    1'b1 |=> fine_step_enable_out == $past(fine_step_enable_in);
  endproperty
  a_fine: assert property (p_fine) else $error("fine step lost");
endmodule
bind sysref_window_capture sysref_window_capture_props #(
  .TAPS(TAPS), .SEL_W(SEL_W), .CNT_W(CNT_W)) chk_u (.mclk_in(mclk_in),
  .arst_n_in(arst_n_in), .sysref_tap_in(sysref_tap_in),
  .capture_tap_select_in(capture_tap_select_in),
  .fine_step_enable_in(fine_step_enable_in),
  .window_clear_in(window_clear_in), .frame_period_in(frame_period_in),
  .reg_req_in(reg_req_in), .reg_rsp_out(reg_rsp_out),
  .fine_step_enable_out(fine_step_enable_out),
  .sysref_captured_out(sysref_captured_out),
  .frame_count_out(frame_count_out), .frame_boundary_out(frame_boundary_out));
`default_nettype wire

// [tb/sysref_source.sv]
`timescale 1ns/1ps
`default_nettype none
// one sysref pulse per request; taps at or above the edge see it a cycle early
module sysref_source
(
  input  wire logic       mclk_in,
  input  wire logic       fire_in,
  input  wire logic [4:0] edge_tap_in,
  output logic     [23:0] sysref_tap_out
);
  logic [2:0] phase = 3'h0;
  // single pulse, seven cycles long, then low again
  always @(posedge mclk_in)
  begin
    if (fire_in)
      phase <= 3'h1;
    else if (phase != 3'h0)
      phase <= phase + 3'h1;
  end
  always_comb
  begin
    for (int i = 0; i < 24; i++)
      sysref_tap_out[i] = (phase > 3'h1) || (phase == 3'h1 && i >= edge_tap_in);
  end
endmodule
`default_nettype wire

// [tb/sysref_window_capture_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module sysref_window_capture_tb;
  import sysref_window_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic        fine = 1'b1;
  logic        clear = 1'b0;
  logic        fire = 1'b0;
  logic [4:0]  edge_tap = 5'h05;
  logic [23:0] taps;
  reg_req_type req = '0;
  reg_rsp_type rsp;
  logic        fine_out, captured, boundary;
  logic [15:0] count;
  int          mismatches = 0;
  int          n_tests = 0;
  sysref_source src_u (.mclk_in(mclk), .fire_in(fire),
    .edge_tap_in(edge_tap), .sysref_tap_out(taps));
  sysref_window_capture dut_u (.mclk_in(mclk), .arst_n_in(rst_n),
    .sysref_tap_in(taps), .capture_tap_select_in(sel),
    .fine_step_enable_in(fine), .window_clear_in(clear),
    .frame_period_in(16'h0007), .reg_req_in(req), .reg_rsp_out(rsp),
    .fine_step_enable_out(fine_out), .sysref_captured_out(captured),
    .frame_count_out(count), .frame_boundary_out(boundary));
  initial forever #12.5 mclk = ~mclk;
  // --------------------------------------------------------------
  // shared helpers
  // --------------------------------------------------------------
  task complete_run;
    if (mismatches == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task check(string what, logic [23:0] exp, logic [23:0] got);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // inputs move 2 ns after the edge, away from sampling
  task cyc(int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task rd(logic [7:0] a, logic [7:0] exp);
    req = '{1'b1, a};
    cyc(1);
    // answer stands for the one cycle after the edge that took the read
    check("valid", 24'h1, {23'h0, rsp.valid});
    check("data", {16'h0, exp}, {16'h0, rsp.data});
    req.rd = 1'b0;
    cyc(1);
    check("idle", 24'h0, {23'h0, rsp.valid});
  endtask
  // pulse, then count cycles until the capture strobe
  task fire_wait(output int n);
    fire = 1'b1;
    cyc(1);
    fire = 1'b0;
    n = 0;
    while (captured !== 1'b1 && n < 12)
    begin
      cyc(1);
      n++;
    end
    check("capture", 24'h1, {23'h0, captured});
  endtask
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task t_map;
    rd(8'h2C, 8'h01);
    rd(8'h2D, 8'h00);
    rd(8'h2E, 8'h80);
    rd(8'h2F, 8'h00);
  endtask
  task t_window(logic [4:0] e, logic [7:0] lo, logic [7:0] mid);
    int n;
    edge_tap = e;
    fire_wait(n);
    cyc(10);
    rd(8'h2C, lo);
    rd(8'h2D, mid);
    rd(8'h2E, 8'h80);
    clear = 1'b1;
    cyc(1);
    clear = 1'b0;
    cyc(4);
    rd(8'h2D, 8'h00);
    rd(8'h2C, 8'h01);
  endtask
  task t_capture;
    int n7, n3;
    edge_tap = 5'h05;
    sel = 4'h7;
    fire_wait(n7);
    cyc(10);
    sel = 4'h3;
    fire_wait(n3);
    check("late tap", 24'(n7 + 1), 24'(n3));
    check("strobe", 24'h1, {23'h0, captured});
    cyc(1);
    check("reload", 24'h1, {7'h0, count, boundary});
    cyc(7);
    check("count", 24'hE, {7'h0, count, boundary});
    cyc(1);
    check("wrap", 24'h1, {7'h0, count, boundary});
  endtask
  // periodic sysref one and then two multiframes apart; the capture must
  // land on the counter's own wrap so the frame phase never moves
  task t_periodic;
    int n;
    edge_tap = 5'h05;
    sel = 4'h3;
    fire_wait(n);
    for (int p = 8; p <= 16; p += 8)
    begin
      cyc(p - n - 1);
      fire_wait(n);
      check("phase", 24'hE, {7'h0, count, boundary});
    end
  endtask
  // second power-up mid-run: window restarts, stored tap written back
  task t_repower;
    int n;
    cyc(8);
    edge_tap = 5'h09;
    fire_wait(n);
    cyc(10);
    rd(8'h2D, 8'h03);
    rst_n = 1'b0;
    sel = 4'h0;
    cyc(2);
    check("reset strobe", 24'h0, {23'h0, captured});
    check("reset count", 24'h0, {7'h0, count, boundary});
    rst_n = 1'b1;
    sel = 4'h3;
    rd(8'h2D, 8'h00);
    rd(8'h2C, 8'h01);
    fire_wait(n);
    check("stored tap", 24'h4, 24'(n));
  endtask
  task t_fine;
    fine = 1'b0;
    cyc(2);
    check("coarse", 24'h0, {23'h0, fine_out});
    fine = 1'b1;
    cyc(2);
    check("fine", 24'h1, {23'h0, fine_out});
  endtask
  initial
  begin
    #(25 * 3000);
    mismatches++;
    complete_run;
  end
  initial
  begin
    cyc(3);
    rst_n = 1'b1;
    t_map;
    t_window(5'h05, 8'h31, 8'h00);
    t_window(5'h0C, 8'h01, 8'h18);
    t_capture;
    t_periodic;
    t_fine;
    t_repower;
    complete_run;
  end
endmodule
`default_nettype wire
